// File: hdl/clock_power_trim_pkg.sv
// Holds the register map, field positions, key values and reset values
// shared by both ends of the clock, power and trim control link.
// Assumes a single core clock and 32-bit word-aligned register access.
package clock_power_trim_pkg;

  // --------------------
  // Register byte addresses
  // --------------------
  localparam logic [31:0] ADDR_POWER_KEY_PRE       = 32'hffff0404;
  localparam logic [31:0] ADDR_POWER_CONTROL       = 32'hffff0408;
  localparam logic [31:0] ADDR_POWER_KEY_POST      = 32'hffff040c;
  localparam logic [31:0] ADDR_PRECISION_OSC_COUNT = 32'hffff0448;
  localparam logic [31:0] ADDR_LOWPOWER_OSC_COUNT  = 32'hffff044c;
  localparam logic [31:0] ADDR_CLOCK_SOURCE_SELECT = 32'hffff0464;
  localparam logic [31:0] ADDR_CALIBRATION_CONTROL = 32'hffff0480;
  localparam logic [31:0] ADDR_CALIBRATION_STATUS  = 32'hffff0484;
  localparam logic [31:0] ADDR_BAUD_LOWER_LIMIT    = 32'hffff0488;
  localparam logic [31:0] ADDR_BAUD_UPPER_LIMIT    = 32'hffff048c;
  localparam logic [31:0] ADDR_TRIM_READBACK0      = 32'hffff0490;
  localparam logic [31:0] ADDR_TRIM_READBACK1      = 32'hffff0494;
  localparam logic [31:0] ADDR_USER_TRIM0          = 32'hffff0498;
  localparam logic [31:0] ADDR_USER_TRIM1          = 32'hffff049c;

  // --------------------
  // Key values, fields and reset values
  // --------------------
  localparam logic [31:0] KEY_PRE             = 32'h00000001;
  localparam logic [31:0] KEY_POST            = 32'h000000f4;
  localparam logic [11:0] POWER_CONTROL_RESET = 12'h079;
  localparam logic [11:0] POWER_PLL_KEEP      = 12'h001;
  localparam int          CLKSEL_BIT          = 0;
  localparam logic        CLKSEL_RESET        = 1'b0;
  localparam int          CAL_ENABLE_BIT      = 0;
  localparam int          CAL_STEP_LSB        = 1;
  localparam logic [2:0]  CAL_CONTROL_RESET   = 3'h0;
  localparam int          STATUS_ALTERED_BIT  = 0;
  localparam int          STATUS_IN_RANGE_BIT = 2;
  localparam logic [7:0]  TRIM_RESET          = 8'h80;
  localparam logic [15:0] BAUD_LIMIT_RESET    = 16'h0000;
  localparam int          PRECISION_COUNT_W   = 9;
  localparam int          LOWPOWER_COUNT_W    = 10;
  localparam int          LOWPOWER_READ_W     = 11;

  // Host command set.
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_POWER, OP_CLKSEL, OP_TRIM_SAVE} host_op_t;

endpackage

// File: hdl/clock_power_trim_if.sv
// Carries register accesses and the measured baud value between the host
// end and the clock, power and trim controller.
// Assumes both ends run on clk_sys and share the synchronous reset srst.
`timescale 1ns/1ps
interface clock_power_trim_if (
  input wire logic clk_sys,
  input wire logic srst
);
  logic        wr_en;
  logic        rd_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;
  logic [15:0] measured_baud_value;
  logic        baud_valid;

  modport device (input clk_sys, srst, wr_en, rd_en, addr, wdata, measured_baud_value, baud_valid,
                  output rdata, rvalid);
  modport host (input clk_sys, srst, rdata, rvalid,
                output wr_en, rd_en, addr, wdata, measured_baud_value, baud_valid);
endinterface

// File: hdl/osc_tick_counter.sv
// Free-running counter advanced by rising edges of an oscillator pin.
// Assumes the oscillator is far slower than clk_sys, so no edge is missed.
`timescale 1ns/1ps
module osc_tick_counter #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             osc_in,
  output logic      [WIDTH-1:0] count
);
  logic sync_a;
  logic sync_b;
  logic prev;

  // Two-stage synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge clk_sys) begin
    sync_a <= osc_in;
    sync_b <= sync_a;
    prev   <= sync_b;
  end

  // Count every rising edge and wrap at the top.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= '0;
    end else if (sync_b && !prev) begin
      count <= count + 1'b1;
    end
  end
endmodule // osc_tick_counter

// File: hdl/clock_power_trim_control.sv
// Clock source select, keyed power control, oscillator counters and the
// baud-driven oscillator trim calibrator, as one register-mapped device.
// Assumes single-cycle register writes and reads on clk_sys from the host.
//
// What this block and its host software do
// - Select bit zero picks the PLL reference.
// - Software writes reserved select bits as zero.
// - Software idles one cycle after a source switch.
// - Pre-key must precede a power control write.
// - Post-key must follow a power control write.
// - Power control: 12 bits, reset 079, mode.
// - Nine-bit counter runs on precision oscillator.
// - Ten-bit low power counter, read eleven bits.
// - Keep PLL powered during ADC normal operation.
// - Trim derived from fixed-rate baud measurement.
// - Out-of-limit baud steps selected oscillator trim.
// - Two read-only registers show applied trims.
// - Calibration never alters the user trim registers.
// - Software copies trims to user before disabling.
// - Status flags trim altered by calibrator.
// - Control bits two-one give steps one-four.
// - Control bit zero enables automatic trim.
`timescale 1ns/1ps
module clock_power_trim_control #(
  parameter int TRIM_W = 8,
  parameter int BAUD_W = 16
) (
  clock_power_trim_if.device        bus,
  input  wire logic                 precision_osc_in,
  input  wire logic                 lowpower_osc_in,
  output logic                      pll_ref_select,
  output logic [11:0]               power_mode,
  output logic [TRIM_W-1:0]         trim_lowpower,
  output logic [TRIM_W-1:0]         trim_precision
);
  // --------------------
  // Storage
  // --------------------
  typedef enum {KEY_IDLE, KEY_ARMED, KEY_HELD} key_state_t;

  key_state_t              key_state;
  logic [11:0]             power_control;
  logic [11:0]             power_pending;
  logic                    clock_source_select;
  logic [2:0]              calibration_control;
  logic [BAUD_W-1:0]       baud_lower_limit;
  logic [BAUD_W-1:0]       baud_upper_limit;
  logic [TRIM_W-1:0]       user_trim [2];
  logic [TRIM_W-1:0]       trim_value_readback [2];
  logic                    status_altered;
  logic                    status_in_range;
  logic [clock_power_trim_pkg::PRECISION_COUNT_W-1:0] precision_osc_count;
  logic [clock_power_trim_pkg::LOWPOWER_COUNT_W-1:0]  lowpower_osc_count;

  logic       cal_enable;
  logic [2:0] step_size;
  logic       baud_low;
  logic       baud_high;
  logic       cal_adjust;
  logic [1:0] adjust_hit;

  localparam logic [31:0] ADDR_USER_TRIM [2] = '{clock_power_trim_pkg::ADDR_USER_TRIM0,
                                                 clock_power_trim_pkg::ADDR_USER_TRIM1};

  // --------------------
  // Oscillator counters
  // --------------------
  osc_tick_counter #(.WIDTH(clock_power_trim_pkg::PRECISION_COUNT_W)) u_precision_count (
    .clk_sys (bus.clk_sys),
    .srst    (bus.srst),
    .osc_in  (precision_osc_in),
    .count   (precision_osc_count)
  );

  osc_tick_counter #(.WIDTH(clock_power_trim_pkg::LOWPOWER_COUNT_W)) u_lowpower_count (
    .clk_sys (bus.clk_sys),
    .srst    (bus.srst),
    .osc_in  (lowpower_osc_in),
    .count   (lowpower_osc_count)
  );

  // --------------------
  // Keyed power control
  // --------------------
  // The key sequencer watches every write; any stray write in the middle of a
  // sequence drops it, so a half-finished sequence can never commit later.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      key_state     <= KEY_IDLE;
      power_pending <= clock_power_trim_pkg::POWER_CONTROL_RESET;
    end else if (bus.wr_en) begin
      case (key_state)
        KEY_IDLE: begin
          if (bus.addr == clock_power_trim_pkg::ADDR_POWER_KEY_PRE &&
              bus.wdata == clock_power_trim_pkg::KEY_PRE) begin
            key_state <= KEY_ARMED;
          end
        end
        KEY_ARMED: begin
          if (bus.addr == clock_power_trim_pkg::ADDR_POWER_CONTROL) begin
            power_pending <= bus.wdata[11:0];
            key_state     <= KEY_HELD;
          end else if (bus.addr == clock_power_trim_pkg::ADDR_POWER_KEY_PRE &&
                       bus.wdata == clock_power_trim_pkg::KEY_PRE) begin
            key_state <= KEY_ARMED;
          end else begin
            key_state <= KEY_IDLE;
          end
        end
        KEY_HELD: begin
          key_state <= KEY_IDLE;
        end
        default: begin
          key_state <= KEY_IDLE;
        end
      endcase
    end
  end

  // The held value only lands when the very next write is the post-key.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      power_control <= clock_power_trim_pkg::POWER_CONTROL_RESET;
    end else if (bus.wr_en && key_state == KEY_HELD &&
                 bus.addr == clock_power_trim_pkg::ADDR_POWER_KEY_POST &&
                 bus.wdata == clock_power_trim_pkg::KEY_POST) begin
      power_control <= power_pending;
    end
  end

  // --------------------
  // Clock source and calibration settings
  // --------------------
  // Reserved select bits are not stored, so they read back as zero.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      clock_source_select <= clock_power_trim_pkg::CLKSEL_RESET;
      calibration_control <= clock_power_trim_pkg::CAL_CONTROL_RESET;
      baud_lower_limit    <= clock_power_trim_pkg::BAUD_LIMIT_RESET;
      baud_upper_limit    <= clock_power_trim_pkg::BAUD_LIMIT_RESET;
    end else if (bus.wr_en) begin
      case (bus.addr)
        clock_power_trim_pkg::ADDR_CLOCK_SOURCE_SELECT:
          clock_source_select <= bus.wdata[clock_power_trim_pkg::CLKSEL_BIT];
        clock_power_trim_pkg::ADDR_CALIBRATION_CONTROL:
          calibration_control <= bus.wdata[2:0];
        clock_power_trim_pkg::ADDR_BAUD_LOWER_LIMIT:
          baud_lower_limit <= bus.wdata[BAUD_W-1:0];
        clock_power_trim_pkg::ADDR_BAUD_UPPER_LIMIT:
          baud_upper_limit <= bus.wdata[BAUD_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------
  // Calibrator
  // --------------------
  // A short baud count means the local oscillator runs slow, so trim goes up.
  assign cal_enable = calibration_control[clock_power_trim_pkg::CAL_ENABLE_BIT];
  assign step_size  = {1'b0, calibration_control[clock_power_trim_pkg::CAL_STEP_LSB +: 2]} + 3'd1;
  assign baud_low   = bus.measured_baud_value < baud_lower_limit;
  assign baud_high  = bus.measured_baud_value > baud_upper_limit;
  assign cal_adjust = cal_enable && bus.baud_valid && (baud_low || baud_high);

  // Index 0 is the low power oscillator and index 1 the precision one,
  // matching the clock source select encoding.
  for (genvar i = 0; i < 2; i++) begin : g_trim
    logic [TRIM_W:0] sum_up;
    logic [TRIM_W:0] sum_dn;

    assign sum_up        = {1'b0, trim_value_readback[i]} + {{(TRIM_W-2){1'b0}}, step_size};
    assign sum_dn        = {1'b0, trim_value_readback[i]} - {{(TRIM_W-2){1'b0}}, step_size};
    assign adjust_hit[i] = cal_adjust && (clock_source_select == 1'(i));

    // The user copy only ever changes on a software write.
    always_ff @(posedge bus.clk_sys) begin
      if (bus.srst) begin
        user_trim[i] <= clock_power_trim_pkg::TRIM_RESET;
      end else if (bus.wr_en && bus.addr == ADDR_USER_TRIM[i]) begin
        user_trim[i] <= bus.wdata[TRIM_W-1:0];
      end
    end

    // Applied trim follows the user copy while idle and saturates at the ends.
    always_ff @(posedge bus.clk_sys) begin
      if (bus.srst) begin
        trim_value_readback[i] <= clock_power_trim_pkg::TRIM_RESET;
      end else if (!cal_enable) begin
        trim_value_readback[i] <= user_trim[i];
      end else if (adjust_hit[i] && baud_low) begin
        trim_value_readback[i] <= sum_up[TRIM_W] ? '1 : sum_up[TRIM_W-1:0];
      end else if (adjust_hit[i]) begin
        trim_value_readback[i] <= sum_dn[TRIM_W] ? '0 : sum_dn[TRIM_W-1:0];
      end
    end
  end

  // Altered flag is sticky; a new adjustment beats a clear in the same cycle.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      status_altered  <= 1'b0;
      status_in_range <= 1'b0;
    end else begin
      if (|adjust_hit) begin
        status_altered <= 1'b1;
      end else if (bus.wr_en && bus.addr == clock_power_trim_pkg::ADDR_CALIBRATION_STATUS &&
                   bus.wdata[clock_power_trim_pkg::STATUS_ALTERED_BIT]) begin
        status_altered <= 1'b0;
      end
      if (cal_enable && bus.baud_valid) begin
        status_in_range <= !(baud_low || baud_high);
      end
    end
  end

  // --------------------
  // Read port
  // --------------------
  // Reads answer one cycle later; unmapped and write-only addresses give zero.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      bus.rdata  <= 32'h00000000;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= bus.rd_en;
      bus.rdata  <= 32'h00000000;
      if (bus.rd_en) begin
        case (bus.addr)
          clock_power_trim_pkg::ADDR_POWER_CONTROL:       bus.rdata <= {20'h00000, power_control};
          clock_power_trim_pkg::ADDR_PRECISION_OSC_COUNT: bus.rdata <= {23'h000000, precision_osc_count};
          clock_power_trim_pkg::ADDR_LOWPOWER_OSC_COUNT:  bus.rdata <= {21'h000000, 1'b0, lowpower_osc_count};
          clock_power_trim_pkg::ADDR_CLOCK_SOURCE_SELECT: bus.rdata <= {31'h00000000, clock_source_select};
          clock_power_trim_pkg::ADDR_CALIBRATION_CONTROL: bus.rdata <= {29'h00000000, calibration_control};
          clock_power_trim_pkg::ADDR_CALIBRATION_STATUS:
            bus.rdata <= {29'h00000000, status_in_range, 1'b0, status_altered};
          clock_power_trim_pkg::ADDR_BAUD_LOWER_LIMIT:    bus.rdata <= 32'(baud_lower_limit);
          clock_power_trim_pkg::ADDR_BAUD_UPPER_LIMIT:    bus.rdata <= 32'(baud_upper_limit);
          clock_power_trim_pkg::ADDR_TRIM_READBACK0:      bus.rdata <= 32'(trim_value_readback[0]);
          clock_power_trim_pkg::ADDR_TRIM_READBACK1:      bus.rdata <= 32'(trim_value_readback[1]);
          clock_power_trim_pkg::ADDR_USER_TRIM0:          bus.rdata <= 32'(user_trim[0]);
          clock_power_trim_pkg::ADDR_USER_TRIM1:          bus.rdata <= 32'(user_trim[1]);
          default:                                        bus.rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Outputs come straight from the holding flops.
  assign pll_ref_select = clock_source_select;
  assign power_mode     = power_control;
  assign trim_lowpower  = trim_value_readback[0];
  assign trim_precision = trim_value_readback[1];
endmodule // clock_power_trim_control

// File: hdl/clock_power_trim_host.sv
// Host end: turns user commands into register accesses, including the keyed
// power write, the clock switch pause and the trim save sequence.
// Assumes the device answers reads exactly one cycle after rd_en.
`timescale 1ns/1ps
module clock_power_trim_host (
  clock_power_trim_if.host                  bus,
  input  wire logic                         cmd_valid,
  input  wire clock_power_trim_pkg::host_op_t cmd_op,
  input  wire logic [31:0]                  cmd_addr,
  input  wire logic [31:0]                  cmd_data,
  input  wire logic                         adc_normal_active,
  input  wire logic [15:0]                  lin_baud_value,
  input  wire logic                         lin_baud_valid,
  output logic                              cmd_ready,
  output logic [31:0]                       rsp_data,
  output logic                              rsp_valid
);
  // --------------------
  // Sequencer
  // --------------------
  typedef enum {H_IDLE, H_READ, H_KEY_DATA, H_KEY_POST, H_DUMMY, H_RB_READ, H_RB_WAIT, H_CAL_OFF} host_state_t;

  host_state_t state;
  logic [11:0] power_value;
  logic        trim_idx;

  // Baud measurements pass through one register on the way to the device.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      bus.measured_baud_value <= 16'h0000;
      bus.baud_valid          <= 1'b0;
    end else begin
      bus.measured_baud_value <= lin_baud_value;
      bus.baud_valid          <= lin_baud_valid;
    end
  end

  // Keyed writes go out on consecutive cycles so nothing can slip between them.
  always_ff @(posedge bus.clk_sys) begin
    if (bus.srst) begin
      state       <= H_IDLE;
      cmd_ready   <= 1'b0;
      bus.wr_en   <= 1'b0;
      bus.rd_en   <= 1'b0;
      bus.addr    <= 32'h00000000;
      bus.wdata   <= 32'h00000000;
      rsp_data    <= 32'h00000000;
      rsp_valid   <= 1'b0;
      power_value <= 12'h000;
      trim_idx    <= 1'b0;
    end else begin
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            bus.addr  <= cmd_addr;
            bus.wdata <= cmd_data;
            case (cmd_op)
              clock_power_trim_pkg::OP_WRITE: bus.wr_en <= 1'b1;
              clock_power_trim_pkg::OP_READ: begin
                bus.rd_en <= 1'b1;
                cmd_ready <= 1'b0;
                state     <= H_READ;
              end
              clock_power_trim_pkg::OP_POWER: begin
                bus.wr_en   <= 1'b1;
                bus.addr    <= clock_power_trim_pkg::ADDR_POWER_KEY_PRE;
                bus.wdata   <= clock_power_trim_pkg::KEY_PRE;
                power_value <= adc_normal_active ? (cmd_data[11:0] | clock_power_trim_pkg::POWER_PLL_KEEP)
                                                 : cmd_data[11:0];
                cmd_ready   <= 1'b0;
                state       <= H_KEY_DATA;
              end
              clock_power_trim_pkg::OP_CLKSEL: begin
                bus.wr_en <= 1'b1;
                bus.addr  <= clock_power_trim_pkg::ADDR_CLOCK_SOURCE_SELECT;
                bus.wdata <= {31'h00000000, cmd_data[clock_power_trim_pkg::CLKSEL_BIT]};
                cmd_ready <= 1'b0;
                state     <= H_DUMMY;
              end
              clock_power_trim_pkg::OP_TRIM_SAVE: begin
                trim_idx  <= 1'b0;
                cmd_ready <= 1'b0;
                state     <= H_RB_READ;
              end
              default: bus.wr_en <= 1'b0;
            endcase
          end
        end
        H_READ: begin
          if (bus.rvalid) begin
            rsp_data  <= bus.rdata;
            rsp_valid <= 1'b1;
            state     <= H_IDLE;
          end
        end
        H_KEY_DATA: begin
          bus.wr_en <= 1'b1;
          bus.addr  <= clock_power_trim_pkg::ADDR_POWER_CONTROL;
          bus.wdata <= {20'h00000, power_value};
          state     <= H_KEY_POST;
        end
        H_KEY_POST: begin
          bus.wr_en <= 1'b1;
          bus.addr  <= clock_power_trim_pkg::ADDR_POWER_KEY_POST;
          bus.wdata <= clock_power_trim_pkg::KEY_POST;
          state     <= H_IDLE;
        end
        H_DUMMY: begin
          state <= H_IDLE;
        end
        H_RB_READ: begin
          bus.rd_en <= 1'b1;
          bus.addr  <= trim_idx ? clock_power_trim_pkg::ADDR_TRIM_READBACK1
                                : clock_power_trim_pkg::ADDR_TRIM_READBACK0;
          state     <= H_RB_WAIT;
        end
        H_RB_WAIT: begin
          if (bus.rvalid) begin
            bus.wr_en <= 1'b1;
            bus.addr  <= trim_idx ? clock_power_trim_pkg::ADDR_USER_TRIM1
                                  : clock_power_trim_pkg::ADDR_USER_TRIM0;
            bus.wdata <= bus.rdata;
            trim_idx  <= 1'b1;
            state     <= trim_idx ? H_CAL_OFF : H_RB_READ;
          end
        end
        H_CAL_OFF: begin
          bus.wr_en <= 1'b1;
          bus.addr  <= clock_power_trim_pkg::ADDR_CALIBRATION_CONTROL;
          bus.wdata <= 32'h00000000;
          state     <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // clock_power_trim_host

// File: tb/clock_power_trim_props.sv
// Concurrent checks on the register link between host and device.
// Assumes plain link signals and the synchronous, active high srst.
`timescale 1ns/1ps
module clock_power_trim_props (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rvalid
);
  // --------------------
  // Link properties
  // --------------------
  // One clock domain, so the clock and reset are given once here.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_pre;
    wr_en && addr == clock_power_trim_pkg::ADDR_POWER_KEY_PRE && wdata == clock_power_trim_pkg::KEY_PRE;
  endsequence
  sequence s_ctl; wr_en && addr == clock_power_trim_pkg::ADDR_POWER_CONTROL; endsequence
  sequence s_post;
    wr_en && addr == clock_power_trim_pkg::ADDR_POWER_KEY_POST && wdata == clock_power_trim_pkg::KEY_POST;
  endsequence
  sequence s_sel; wr_en && addr == clock_power_trim_pkg::ADDR_CLOCK_SOURCE_SELECT; endsequence
  property p_read_answer; rd_en |=> rvalid; endproperty
  property p_idle_zero; !rvalid |-> rdata == 32'h0; endproperty
  property p_pre_first; s_pre |=> s_ctl; endproperty
  property p_post_after; s_pre ##1 s_ctl |=> s_post; endproperty
  property p_sel_zero; s_sel |-> wdata[31:1] == 31'h0; endproperty
  property p_sel_gap; s_sel |=> !wr_en && !rd_en; endproperty
  property p_lp_width;
    rd_en && addr == clock_power_trim_pkg::ADDR_LOWPOWER_OSC_COUNT |=> rdata[31:10] == 22'h0;
  endproperty
  property p_pr_width;
    rd_en && addr == clock_power_trim_pkg::ADDR_PRECISION_OSC_COUNT |=> rdata[31:9] == 23'h0;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
  a_pre_first: assert property (p_pre_first) else $error("pre key not followed by power write");
  a_post_after: assert property (p_post_after) else $error("power write without post key");
  a_sel_zero: assert property (p_sel_zero) else $error("reserved select bits set");
  a_sel_gap: assert property (p_sel_gap) else $error("no idle cycle after switch");
  a_lp_width: assert property (p_lp_width) else $error("low power count too wide");
  a_pr_width: assert property (p_pr_width) else $error("precision count too wide");
endmodule // clock_power_trim_props

// File: tb/tb_clock_power_trim_control.sv
// Testbench: host and device joined by the link, driven through host commands.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_clock_power_trim_control;
  logic        clk_sys, srst, cmd_valid, adc_normal_active, lin_baud_valid, cmd_ready, rsp_valid, pll_ref_select;
  logic        precision_osc_in = 1'b0;
  logic        lowpower_osc_in  = 1'b0;
  logic [31:0] cmd_addr, cmd_data, rsp_data, d;
  logic [15:0] lin_baud_value;
  logic [11:0] power_mode;
  logic [7:0]  trim_lowpower, trim_precision, trim;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;
  clock_power_trim_pkg::host_op_t cmd_op;
  clock_power_trim_if link (.clk_sys, .srst);
  clock_power_trim_control clock_power_trim_control_inst (.bus(link), .precision_osc_in, .lowpower_osc_in,
    .pll_ref_select, .power_mode, .trim_lowpower, .trim_precision);
  clock_power_trim_host clock_power_trim_host_inst (.bus(link), .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
    .adc_normal_active, .lin_baud_value, .lin_baud_valid, .cmd_ready, .rsp_data, .rsp_valid);
  clock_power_trim_props clock_power_trim_props_inst (.clk_sys, .srst, .wr_en(link.wr_en),
    .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
  // --------------------
  // Clock, slow oscillator pins and the hang limit
  // --------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The pins are far slower than clk_sys so no edge can be lost in the synchroniser.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    precision_osc_in <= cycles[1];
    lowpower_osc_in <= cycles[2];
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // --------------------
  // Host command tasks
  // --------------------
  task automatic issue(input clock_power_trim_pkg::host_op_t op, input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (cmd_ready !== 1'b1 && n < 60);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= v;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    issue(clock_power_trim_pkg::OP_READ, a, 32'h0);
    do begin @(negedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 8);
    d = rsp_data;
  endtask
  task automatic baud(input logic [15:0] v);
    @(posedge clk_sys);
    lin_baud_value <= v;
    lin_baud_valid <= 1'b1;
    @(posedge clk_sys);
    lin_baud_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    $display("num_errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    {cmd_valid, adc_normal_active, lin_baud_valid, cmd_addr, cmd_data, lin_baud_value} = '0;
    cmd_op = clock_power_trim_pkg::OP_WRITE;
    srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    `CHK(power_mode, clock_power_trim_pkg::POWER_CONTROL_RESET)
    rd(clock_power_trim_pkg::ADDR_POWER_CONTROL); `CHK(d, 32'h079)
    rd(clock_power_trim_pkg::ADDR_POWER_KEY_PRE); `CHK(d, 32'h0)
    issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_POWER_CONTROL, 32'h123);
    rd(clock_power_trim_pkg::ADDR_POWER_CONTROL); `CHK(d, 32'h079)
    @(posedge clk_sys);
    adc_normal_active <= 1'b1;
    issue(clock_power_trim_pkg::OP_POWER, 32'h0, 32'h0a4);
    rd(clock_power_trim_pkg::ADDR_POWER_CONTROL); `CHK(d, 32'h0a5)
    @(posedge clk_sys);
    adc_normal_active <= 1'b0;
    issue(clock_power_trim_pkg::OP_POWER, 32'h0, 32'h0b8);
    rd(clock_power_trim_pkg::ADDR_PRECISION_OSC_COUNT); `CHK(power_mode, 12'h0b8)
    `CHK(d != 32'h0, 1'b1)
    rd(clock_power_trim_pkg::ADDR_LOWPOWER_OSC_COUNT); `CHK(d != 32'h0, 1'b1)
    issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_BAUD_LOWER_LIMIT, 32'h100);
    issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_BAUD_UPPER_LIMIT, 32'h200);
    trim = clock_power_trim_pkg::TRIM_RESET;
    // Every step code in turn; the low power oscillator is the one selected.
    for (int s = 0; s < 4; s++) begin
      issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_CALIBRATION_CONTROL, 32'(s * 2 + 1));
      baud(16'h0050);
      trim = trim + 8'(s + 1);
      `CHK(trim_lowpower, trim)
    end
    baud(16'h0300); trim = trim - 8'h4; `CHK(trim_lowpower, trim)
    baud(16'h0150); `CHK(trim_lowpower, trim)
    `CHK(trim_precision, clock_power_trim_pkg::TRIM_RESET)
    rd(clock_power_trim_pkg::ADDR_CALIBRATION_STATUS); `CHK({d[2], d[0]}, 2'b11)
    rd(clock_power_trim_pkg::ADDR_TRIM_READBACK0); `CHK(d[7:0], trim)
    rd(clock_power_trim_pkg::ADDR_USER_TRIM0); `CHK(d[7:0], clock_power_trim_pkg::TRIM_RESET)
    issue(clock_power_trim_pkg::OP_TRIM_SAVE, 32'h0, 32'h0);
    rd(clock_power_trim_pkg::ADDR_USER_TRIM0); `CHK(d[7:0], trim)
    baud(16'h0050); `CHK(trim_lowpower, trim)
    issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_CALIBRATION_STATUS, 32'h1);
    rd(clock_power_trim_pkg::ADDR_CALIBRATION_STATUS); `CHK(d, 32'h4)
    issue(clock_power_trim_pkg::OP_CLKSEL, 32'h0, 32'h1);
    rd(clock_power_trim_pkg::ADDR_CLOCK_SOURCE_SELECT); `CHK(d, 32'h1)
    `CHK(pll_ref_select, 1'b1)
    issue(clock_power_trim_pkg::OP_WRITE, clock_power_trim_pkg::ADDR_CALIBRATION_CONTROL, 32'h1);
    baud(16'h0300); `CHK(trim_precision, 8'h7f)
    wrap_up();
  end
endmodule // tb_clock_power_trim_control
